// ===== core/signal_mixer.sv
// Purpose: data signal modulator mixing a modulator with two carriers
// Assumes: peripheral sources share the clock; pins are asynchronous
// Notes: control bits are plain ports held by the owning register file
//
// Overview of operation
// (R1) Output is the active carrier gated by the modulator, driven to pin.
// (R2) Modulator high selects carrier high; modulator low selects carrier low.
// (R3) Block is active only while the enable bit is set.
// (R4) Disabled block forces both carriers to the ground source.
// (R5) Disabled block takes the modulator from the software bit.
// (R6) Disabling keeps stored source selections; enabling routes them again.
// (R7) Output gate clear holds the pin low while mixing continues.
// (R8) Four-bit modulator select picks one of eleven sources.
// (R9) Serial data sources count only while their port is in SPI mode.
// (R10) Four-bit carrier-high select picks one of eight sources.
// (R11) Carrier-low select picks from the same eight, independently.
// (R12) With sync, the outgoing carrier pulse finishes low before switching.
// (R13) Each carrier has its own sync enable, applying only to it.
// (R14) Each carrier input has its own polarity inversion bit.
// (R15) Output polarity bit inverts the signal driven to the pin.
// (R16) Reset disables the block and clears its state.
// (R17) Block keeps running in sleep while its sources run.
// (R18) Outgoing carrier already low means an immediate switch.
// (R19) Carrier inversion precedes mixing; output gate follows polarity.
`timescale 1ns/1ps

module signal_mixer
    import signal_mixer_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire signal_mixer_pkg::mixer_cfg_s cfg,
    input wire signal_mixer_pkg::periph_src_s periph,
    input wire logic ext_modulator_pin,
    input wire logic ext_carrier_pin_a,
    input wire logic ext_carrier_pin_b,
    output logic modulated_out_pin,
    output logic mix_value
);
    import signal_mixer_pkg::*;

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [PIN_COUNT-1:0] pin_raw;
    logic [PIN_COUNT-1:0] pin_meta_q;
    logic [PIN_COUNT-1:0] pin_meta_d;
    logic [PIN_COUNT-1:0] pin_sync_q;
    logic [PIN_COUNT-1:0] pin_sync_d;

    assign pin_raw = {ext_carrier_pin_b, ext_carrier_pin_a,
                      ext_modulator_pin};

    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi++)
        begin : g_pin
            always_comb
            begin
                pin_meta_d[gi] = pin_raw[gi];
                pin_sync_d[gi] = pin_meta_q[gi];
            end
        end
    endgenerate

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            pin_meta_q <= PIN_SYNC_RST;
            pin_sync_q <= PIN_SYNC_RST;
        end
        else
        begin
            pin_meta_q <= pin_meta_d;
            pin_sync_q <= pin_sync_d;
        end
    end

    // ****************************************
    // source selection
    // ****************************************
    logic mod_sel;
    logic mod_c;
    logic hi_raw;
    logic lo_raw;
    logic hi_car;
    logic lo_car;

    function automatic logic pick_carrier(input logic [3:0] sel,
                                          input periph_src_s p,
                                          input logic [PIN_COUNT-1:0] pins);
        logic r;
        r = 1'b0;
        case (sel)
            CAR_EXT_A: r = pins[1];
            CAR_EXT_B: r = pins[2];
            CAR_REF_CLK: r = p.ref_clock;
            CAR_CCP_A: r = p.capture_compare[0];
            CAR_CCP_B: r = p.capture_compare[1];
            CAR_CCP_C: r = p.capture_compare[2];
            CAR_CCP_D: r = p.capture_compare[3];
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    always_comb
    begin
        // R8
        case (cfg.mod_source_sel)
            MOD_SW_BIT: mod_sel = cfg.sw_modulator_value;
            MOD_EXT_PIN: mod_sel = pin_sync_q[0];
            MOD_CCP_A: mod_sel = periph.capture_compare[0];
            MOD_CCP_B: mod_sel = periph.capture_compare[1];
            MOD_CCP_C: mod_sel = periph.capture_compare[2];
            MOD_CCP_D: mod_sel = periph.capture_compare[3];
            MOD_COMP_A: mod_sel = periph.comparator_a;
            MOD_COMP_B: mod_sel = periph.comparator_b;
            MOD_UART_TX: mod_sel = periph.uart_tx;
            MOD_SERIAL_A: mod_sel = periph.serial_out_a
                                    & periph.spi_mode_a; // R9
            MOD_SERIAL_B: mod_sel = periph.serial_out_b
                                    & periph.spi_mode_b; // R9
            default: mod_sel = 1'b0;
        endcase
        // selections stay on the ports; disable only overrides the mux
        // R3 R5 R6
        mod_c = cfg.mixer_on_ctl ? mod_sel : cfg.sw_modulator_value;
        // R10 R11 R4
        hi_raw = cfg.mixer_on_ctl
            ? pick_carrier(cfg.hi_carrier_sel, periph, pin_sync_q) : 1'b0;
        lo_raw = cfg.mixer_on_ctl
            ? pick_carrier(cfg.lo_carrier_sel, periph, pin_sync_q) : 1'b0;
        // R14 R19
        hi_car = hi_raw ^ cfg.hi_carrier_invert;
        lo_car = lo_raw ^ cfg.lo_carrier_invert;
    end

    // ****************************************
    // active carrier and synchronisation
    // ****************************************
    active_carrier_e act_q;
    active_carrier_e act_d;
    logic mix_c;
    logic pin_d;
    logic pin_q;
    logic mix_q;

    always_comb
    begin
        act_d = act_q;
        case (act_q)
            ACT_HI:
            begin
                // hold a high pulse until it falls, else switch now
                if (!mod_c && !(cfg.hi_carrier_sync && hi_car)) // R12 R13 R18
                begin
                    act_d = ACT_LO;
                end
            end
            ACT_LO:
            begin
                if (mod_c && !(cfg.lo_carrier_sync && lo_car)) // R12 R13 R18
                begin
                    act_d = ACT_HI;
                end
            end
            default: act_d = ACT_LO;
        endcase
        mix_c = (act_d == ACT_HI) ? hi_car : lo_car; // R1 R2
        // gate after polarity so a closed gate always reads low
        pin_d = cfg.out_pin_gate & (mix_c ^ cfg.output_invert); // R7 R15 R19
    end

    // no clock gating here, so sleep does not stop the mixer; R17
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            act_q <= ACT_LO; // R16
            pin_q <= OUT_PIN_RST;
            mix_q <= OUT_PIN_RST;
        end
        else
        begin
            act_q <= act_d;
            pin_q <= pin_d;
            mix_q <= mix_c;
        end
    end

    assign modulated_out_pin = pin_q;
    assign mix_value = mix_q;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    AST_DIS_CARRIER: assert property ( // R4
        !cfg.mixer_on_ctl |-> (hi_raw == 1'b0) && (lo_raw == 1'b0))
        else $error("disabled mixer did not ground carriers");

    AST_DIS_MOD: assert property ( // R5
        !cfg.mixer_on_ctl |-> mod_c == cfg.sw_modulator_value)
        else $error("disabled mixer did not use software bit");

    AST_SPI_ONLY: assert property ( // R9
        cfg.mixer_on_ctl && cfg.mod_source_sel == MOD_SERIAL_A
        && !periph.spi_mode_a |-> !mod_c)
        else $error("serial source used outside spi mode");

    AST_GATE_LOW: assert property ( // R7
        !cfg.out_pin_gate |=> !modulated_out_pin)
        else $error("closed output gate let the pin rise");

    AST_PIN_VALUE: assert property ( // R15
        cfg.out_pin_gate |=> modulated_out_pin
            == ($past(mix_c) ^ $past(cfg.output_invert)))
        else $error("pin does not follow mix and polarity");

    AST_HI_MIX: assert property ( // R2
        act_q == ACT_HI && mod_c |=> mix_value == $past(hi_car))
        else $error("carrier high not mixed while modulator high");

    AST_SYNC_HOLD: assert property ( // R12
        act_q == ACT_HI && !mod_c && cfg.hi_carrier_sync && hi_car
        |=> act_q == ACT_HI)
        else $error("high carrier pulse truncated under sync");

    AST_NO_SYNC: assert property ( // R13
        act_q == ACT_LO && mod_c && !cfg.lo_carrier_sync
        |=> act_q == ACT_HI)
        else $error("unsynchronised switch was delayed");

    AST_FAST_SWITCH: assert property ( // R18
        act_q == ACT_HI && !mod_c && !hi_car |=> act_q == ACT_LO)
        else $error("low outgoing carrier delayed the switch");

    AST_INVERT: assert property ( // R14
        cfg.mixer_on_ctl && cfg.hi_carrier_sel == CAR_VSS
        |-> hi_car == cfg.hi_carrier_invert)
        else $error("carrier high polarity not applied");

    AST_RESET: assert property (@(posedge clock) disable iff (1'b0) // R16
        !rst_n |=> !modulated_out_pin && act_q == ACT_LO)
        else $error("reset did not clear the mixer");

    AST_LO_MIX: assert property ( // R1
        act_q == ACT_LO && !mod_c |=> mix_value == $past(lo_car))
        else $error("carrier low not mixed while modulator low");

    AST_LO_SYNC_HOLD: assert property ( // R13
        act_q == ACT_LO && mod_c && cfg.lo_carrier_sync && lo_car
        |=> act_q == ACT_LO)
        else $error("low carrier pulse truncated under sync");

    AST_SPI_ONLY_B: assert property ( // R9
        cfg.mixer_on_ctl && cfg.mod_source_sel == MOD_SERIAL_B
        && !periph.spi_mode_b |-> !mod_c)
        else $error("second serial source used outside spi mode");

    AST_ROUTE_AGAIN: assert property ( // R6
        cfg.mixer_on_ctl && cfg.mod_source_sel == MOD_UART_TX
        |-> mod_c == periph.uart_tx)
        else $error("enabled mixer ignored stored modulator source");

    // pin path only valid once both sync flops left reset
    AST_EXT_MOD: assert property ( // R8
        cfg.mixer_on_ctl && cfg.mod_source_sel == MOD_EXT_PIN
        && $past(rst_n) && $past(rst_n, 2)
        |-> mod_c == $past(ext_modulator_pin, 2))
        else $error("external modulator pin not routed");

    AST_HI_SEL: assert property ( // R10
        cfg.mixer_on_ctl && cfg.hi_carrier_sel == CAR_CCP_D
        |-> hi_raw == periph.capture_compare[3])
        else $error("carrier high select did not route its source");

    AST_LO_SEL: assert property ( // R11
        cfg.mixer_on_ctl && cfg.lo_carrier_sel == CAR_REF_CLK
        |-> lo_raw == periph.ref_clock)
        else $error("carrier low select did not route its source");

    AST_DIS_QUIET: assert property ( // R3
        !cfg.mixer_on_ctl && !cfg.hi_carrier_invert
        && !cfg.lo_carrier_invert |=> !mix_value)
        else $error("disabled mixer still produced a carrier");

    AST_GATE_INVERT: assert property ( // R19
        !cfg.out_pin_gate && cfg.output_invert |=> !modulated_out_pin)
        else $error("output polarity leaked past the closed gate");

    COV_SYNC_WAIT: cover property (
        act_q == ACT_HI && !mod_c && cfg.hi_carrier_sync && hi_car);
    COV_LO_WAIT: cover property (
        act_q == ACT_LO && mod_c && cfg.lo_carrier_sync && lo_car);
    COV_SWITCH_LO: cover property (act_q == ACT_HI ##1 act_q == ACT_LO);
    COV_PIN_HIGH: cover property (cfg.mixer_on_ctl ##1 modulated_out_pin);
    COV_GATE_SHUT: cover property (
        cfg.mixer_on_ctl && !cfg.out_pin_gate ##1 mix_value);

endmodule

// ===== include/signal_mixer_pkg.sv
// Purpose: shared constants and carriers for the signal mixer
// Assumes: source codes are fixed for this design
// Notes: unused select codes fall back to a constant low
package signal_mixer_pkg;

    // ****************************************
    // modulator source codes
    // ****************************************
    localparam logic [3:0] MOD_SW_BIT = 4'h0;
    localparam logic [3:0] MOD_EXT_PIN = 4'h1;
    localparam logic [3:0] MOD_CCP_A = 4'h2;
    localparam logic [3:0] MOD_CCP_B = 4'h3;
    localparam logic [3:0] MOD_CCP_C = 4'h4;
    localparam logic [3:0] MOD_CCP_D = 4'h5;
    localparam logic [3:0] MOD_COMP_A = 4'h6;
    localparam logic [3:0] MOD_COMP_B = 4'h7;
    localparam logic [3:0] MOD_UART_TX = 4'h8;
    localparam logic [3:0] MOD_SERIAL_A = 4'h9;
    localparam logic [3:0] MOD_SERIAL_B = 4'hA;

    // ****************************************
    // carrier source codes
    // ****************************************
    localparam logic [3:0] CAR_VSS = 4'h0;
    localparam logic [3:0] CAR_EXT_A = 4'h1;
    localparam logic [3:0] CAR_EXT_B = 4'h2;
    localparam logic [3:0] CAR_REF_CLK = 4'h3;
    localparam logic [3:0] CAR_CCP_A = 4'h4;
    localparam logic [3:0] CAR_CCP_B = 4'h5;
    localparam logic [3:0] CAR_CCP_C = 4'h6;
    localparam logic [3:0] CAR_CCP_D = 4'h7;

    // ****************************************
    // reset values and sizes
    // ****************************************
    localparam int PIN_COUNT = 3;
    localparam int SYNC_STAGES = 2;
    localparam logic [2:0] PIN_SYNC_RST = 3'h0;
    localparam logic OUT_PIN_RST = 1'h0;

    typedef enum logic
    {
        ACT_LO = 1'b0,
        ACT_HI = 1'b1
    } active_carrier_e;

    typedef struct packed
    {
        logic mixer_on_ctl;
        logic out_pin_gate;
        logic output_invert;
        logic sw_modulator_value;
        logic [3:0] mod_source_sel;
        logic [3:0] hi_carrier_sel;
        logic [3:0] lo_carrier_sel;
        logic hi_carrier_sync;
        logic lo_carrier_sync;
        logic hi_carrier_invert;
        logic lo_carrier_invert;
    } mixer_cfg_s;

    typedef struct packed
    {
        logic [3:0] capture_compare;
        logic serial_out_a;
        logic serial_out_b;
        logic spi_mode_a;
        logic spi_mode_b;
        logic comparator_a;
        logic comparator_b;
        logic uart_tx;
        logic ref_clock;
    } periph_src_s;

endpackage

// ===== bench/periph_model.sv
// Purpose: stand-in for the peripherals and pins feeding the mixer
// Assumes: random word comes from the bench generator
// Notes: pins held low while quiet so reset flushes are equal either way
`timescale 1ns/1ps

module periph_model
    import signal_mixer_pkg::*;
(
    input wire logic clock,
    input wire logic quiet,
    input wire logic [31:0] rnd,
    output signal_mixer_pkg::periph_src_s periph,
    output logic [2:0] pins
);
    import signal_mixer_pkg::*;

    // sources stay unknown until the first falling edge, inside reset
    logic ref_q = 1'b0;

    // ****************************************
    // sources change on the falling edge
    // ****************************************
    always @(negedge clock)
    begin
        ref_q <= ~ref_q;
        periph <= {rnd[10:0], ref_q};
        pins <= quiet ? 3'h0 : rnd[14:12];
    end
endmodule

// ===== bench/tb_top.sv
// Purpose: self-checking bench for the signal mixer
// Assumes: sources and pins change only on the falling edge
// Notes: every falling edge compares both outputs with the model
`timescale 1ns/1ps

`define CHK(nm, e, g) \
    begin \
        checked++; \
        if ((e) !== (g)) \
        begin \
            err_total++; \
            $display("mismatch %s exp %0b got %0b", nm, e, g); \
        end \
    end

module tb_top;
    import signal_mixer_pkg::*;

    logic clock, rst_n, quiet, modulated_out_pin, mix_value;
    logic m_pin, m_mix, act, en, md, ch, cl;
    mixer_cfg_s cfg, c;
    periph_src_s per;
    logic [2:0] pins, s1, s2;
    logic [31:0] rnd, p_rnd;
    logic [10:0] ms;
    logic [7:0] cs;
    int checked, err_total;

    always #5 clock = ~clock;

    periph_model i_src (.clock(clock), .quiet(quiet), .rnd(p_rnd),
        .periph(per), .pins(pins));

    signal_mixer i_dut (.clock(clock), .rst_n(rst_n), .cfg(cfg),
        .periph(per), .ext_modulator_pin(pins[0]),
        .ext_carrier_pin_a(pins[1]), .ext_carrier_pin_b(pins[2]),
        .modulated_out_pin(modulated_out_pin), .mix_value(mix_value));

    // ****************************************
    // reference model
    // ****************************************
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            act = 1'b0;
            m_pin = 1'b0;
            m_mix = 1'b0;
            s1 = 3'h0;
            s2 = 3'h0;
        end
        else
        begin
            en = cfg.mixer_on_ctl;
            ms = {per.serial_out_b & per.spi_mode_b,
                per.serial_out_a & per.spi_mode_a, per.uart_tx,
                per.comparator_b, per.comparator_a, per.capture_compare,
                s2[0], cfg.sw_modulator_value};
            cs = {per.capture_compare, per.ref_clock, s2[2], s2[1], 1'b0};
            if (!en)
                md = cfg.sw_modulator_value;
            else
                md = (cfg.mod_source_sel < 11) ? ms[cfg.mod_source_sel] : 0;
            ch = (en && cfg.hi_carrier_sel < 8) ? cs[cfg.hi_carrier_sel] : 0;
            cl = (en && cfg.lo_carrier_sel < 8) ? cs[cfg.lo_carrier_sel] : 0;
            ch = ch ^ cfg.hi_carrier_invert;
            cl = cl ^ cfg.lo_carrier_invert;
            // sync only holds a carrier that is still high
            if (act && !md && !(cfg.hi_carrier_sync && ch))
                act = 1'b0;
            else if (!act && md && !(cfg.lo_carrier_sync && cl))
                act = 1'b1;
            m_mix = act ? ch : cl;
            m_pin = cfg.out_pin_gate & (m_mix ^ cfg.output_invert);
            s2 = s1;
            s1 = pins;
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], 1'b0} ^ (v[31] ? 32'h04C11DB7 : 32'h0);
    endfunction

    // ****************************************
    // stimulus and checks
    // ****************************************
    task automatic step(input int n, input int sel);
        for (int i = 0; i < n; i++)
        begin
            @(negedge clock);
            `CHK("modulated_out_pin", m_pin, modulated_out_pin)
            `CHK("mix_value", m_mix, mix_value)
            rnd = lfsr(rnd);
            p_rnd <= rnd;
            // slow config change leaves room for sync hold-offs
            if (rnd[31:29] == 3'h0)
                c = rnd[19:0];
            if (sel >= 0)
            begin
                c.mixer_on_ctl = rnd[21] | rnd[22];
                c.mod_source_sel = sel[3:0];
                c.hi_carrier_sel = sel[3:0];
                c.lo_carrier_sel = 4'hF - sel[3:0];
            end
            c.sw_modulator_value = rnd[20];
            cfg <= c;
        end
    endtask

    task automatic wrap_up();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        clock = 1'b0;
        rst_n = 1'b0;
        quiet = 1'b1;
        cfg = '0;
        c = '0;
        rnd = 32'h193814C5;
        p_rnd = 32'h0;
        step(6, -1);
        rst_n <= 1'b1;
        step(2, -1);
        quiet <= 1'b0;
        for (int k = 0; k < 16; k++)
            step(60, k);
        step(3000, -1);
        quiet <= 1'b1;
        step(3, -1);
        rst_n <= 1'b0;
        step(3, -1);
        rst_n <= 1'b1;
        step(2, -1);
        quiet <= 1'b0;
        step(500, -1);
        wrap_up();
    end
endmodule
